// ===== dv/ster_mst.sv
/* Network master model: register writes, reads and error acknowledge.
   Assumes read data stand in the cycle after the read strobe. */
`timescale 1ns/100ps
module ster_mst (
    // Clock and read data.
    input  wire logic        i_core_clk,
    input  wire logic [15:0] i_rdata,
    // Register port.
    output logic      [11:0] o_addr,
    output logic      [15:0] o_wdata,
    output logic             o_wr,
    output logic             o_rd
);
    initial begin
        o_addr = 12'h000;
        o_wdata = 16'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_core_clk);
        o_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [15:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_core_clk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
    task automatic ack(input logic [3:0] st);
        wr(12'h0120, {11'h000, 1'b1, st});
    endtask
endmodule // ster_mst

// ===== dv/ster_top_asserts.sv
/* Checker for the state error block, bound to its top ports.
   Assumes the fault view and cold start reads happen with steady faults. */
`timescale 1ns/100ps
module ster_top_asserts (
    // Clock and reset.
    input wire logic                          i_core_clk,
    input wire logic                          i_rst_b,
    // Register port.
    input wire logic [11:0]                   i_addr,
    input wire logic [15:0]                   i_wdata,
    input wire logic                          i_wr,
    input wire logic                          i_rd,
    input wire logic [15:0]                   o_rdata,
    // Faults and interrupt.
    input wire logic [ster_pkg::FC_WIDTH-1:0] i_fault,
    input wire logic                          o_irq
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    property p_idle; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero outside a read");
    property p_unmap; i_rd && i_addr == 12'h002 |=> o_rdata == 16'h0000; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_report;
        i_rd && i_addr == ster_pkg::OFS_STATE_REPORT |=> o_rdata[15:5] == 11'h000 && o_rdata[3:0] inside {1, 2, 3, 4, 8};
    endproperty
    a_report: assert property (p_report) else $error("bad state report");
    property p_view; i_rd && i_addr == ster_pkg::OFS_FAULT_CAUSE && $stable(i_fault) |=> o_rdata == 16'($past(i_fault));
    endproperty
    a_view: assert property (p_view) else $error("fault view mismatch");
    sequence s_cold; i_fault[6] && $past(i_fault[6]) && !$past(i_wr) && i_rd; endsequence
    property p_cold_code; s_cold and i_addr == ster_pkg::OFS_ERROR_CODE |=> o_rdata == 16'h0020; endproperty
    a_cold_code: assert property (p_cold_code) else $error("cold start code missing");
    property p_cold_flag; s_cold and i_addr == ster_pkg::OFS_STATE_REPORT |=> o_rdata[4]; endproperty
    a_cold_flag: assert property (p_cold_flag) else $error("cold start flag missing");
    property p_mask; i_wr && i_addr == ster_pkg::OFS_IRQ_ENABLE && i_wdata[2:0] == 3'h0 |-> ##2 !o_irq; endproperty
    a_mask: assert property (p_mask) else $error("masked interrupt still high");
    property p_rst; $rose(i_rst_b) |-> !o_irq ##1 !o_irq; endproperty
    a_rst: assert property (p_rst) else $error("interrupt high after reset");
    c_cold: cover property (s_cold);
    c_irq: cover property ($rose(o_irq));
    c_unmap: cover property (i_rd && i_addr == 12'h002);
endmodule // ster_top_asserts
bind ster_top ster_top_asserts i_chk (.i_core_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_fault, .o_irq);

// ===== dv/tb_top.sv
/* Testbench: state changes, faults, interrupts and emulation.
   Assumes the master model drives the register port. */
`timescale 1ns/100ps
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", n, e, v); end end
module tb_top;
    logic        i_core_clk;
    logic        i_rst_b;
    logic [11:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        wr;
    logic        rd;
    logic        irq;
    logic [6:0]  fault;
    logic [47:0] tbl [21];
    int          errors;
    int          total_checks;
    int          cycles;
    ster_top i_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
                    .i_rd(rd), .o_rdata(rdata), .i_fault(fault), .o_irq(irq));
    ster_mst i_mst (.i_core_clk(i_core_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    task automatic end_of_test;
        if (errors == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic rdc(input logic [11:0] a, input logic [15:0] e);
        logic [15:0] v;
        i_mst.rd(a, v);
        `CHK($sformatf("reg %h", a), e, v)
    endtask
    task automatic irqc(input logic e);
        repeat (3) @(posedge i_core_clk);
        #1;
        `CHK("irq", e, irq)
    endtask
    // Row: request (FFFF for none), fault, expected report, expected code.
    task automatic step(input logic [47:0] s);
        @(posedge i_core_clk);
        fault <= s[30:24];
        if (s[47:32] != 16'hFFFF) i_mst.wr(12'h0120, s[47:32]);
        repeat (2) @(posedge i_core_clk);
        rdc(12'h0130, {8'h00, s[23:16]});
        rdc(12'h0134, s[15:0]);
        rdc(12'h0150, {9'h000, s[30:24]});
        @(posedge i_core_clk);
        fault <= 7'h00;
        if (s[20]) begin
            i_mst.ack(s[19:16]);
            rdc(12'h0130, {12'h000, s[19:16]});
        end
    endtask
    initial begin
        i_rst_b = 1'b0;
        fault = 7'h00;
        cycles = 0;
        errors = 0;
        total_checks = 0;
        tbl = '{48'h0004_0011_0011, 48'h0008_0011_0011, 48'h0002_0002_0000, 48'h0008_0012_0011,
                48'h0003_0012_0011, 48'h0004_0112_0017, 48'h0004_0412_001C, 48'h0004_0212_0018,
                48'h0004_0004_0000, 48'h0003_0014_0011, 48'h0008_0008_0000, 48'h0003_0018_0011,
                48'hFFFF_0814_0030, 48'h0008_0008_0000, 48'hFFFF_1014_0031, 48'h0008_0008_0000,
                48'hFFFF_2014_0034, 48'h0008_0008_0000, 48'hFFFF_0414_001C, 48'hFFFF_0212_0018,
                48'hFFFF_4012_0020};
        repeat (3) @(posedge i_core_clk);
        i_rst_b <= 1'b1;
        repeat (3) @(posedge i_core_clk);
        rdc(12'h0130, 16'h0001);
        rdc(12'h0134, 16'h0000);
        rdc(12'h0168, 16'h0000);
        rdc(12'h0140, 16'h0000);
        rdc(12'h0002, 16'h0000);
        foreach (tbl[i]) step(tbl[i]);
        i_mst.wr(12'h0164, 16'h0007);
        rdc(12'h0160, 16'h0000);
        i_mst.wr(12'h0168, 16'h0001);
        rdc(12'h0168, 16'h0001);
        irqc(1'b0);
        i_mst.wr(12'h0120, 16'h0008);
        irqc(1'b1);
        i_mst.wr(12'h0168, 16'h0000);
        irqc(1'b0);
        i_mst.wr(12'h0168, 16'h0001);
        irqc(1'b1);
        i_mst.wr(12'h0164, 16'h0001);
        irqc(1'b0);
        i_mst.wr(12'h0134, 16'h1234);
        rdc(12'h0134, 16'h0011);
        i_mst.wr(12'h0002, 16'hFFFF);
        rdc(12'h0002, 16'h0000);
        i_mst.ack(4'h2);
        i_mst.wr(12'h0140, 16'h0100);
        rdc(12'h0140, 16'h0100);
        i_mst.wr(12'h0120, 16'h0018);
        rdc(12'h0130, 16'h0018);
        i_mst.wr(12'h0120, 16'h0008);
        rdc(12'h0130, 16'h0008);
        rdc(12'h0160, 16'h0006);
        i_mst.wr(12'h0168, 16'h0002);
        irqc(1'b1);
        i_mst.wr(12'h0164, 16'h0006);
        irqc(1'b0);
        i_mst.wr(12'h0140, 16'h0000);
        end_of_test();
    end
endmodule // tb_top

// ===== inc/ster_pkg.sv
/*
 * Package for the state transition error reporting block: register offsets,
 * field positions, state encodings, error codes and interrupt layout.
 * Assumes a 16-bit register word reached over a plain strobe port.
 */
package ster_pkg;
    // Register offsets (byte addresses).
    localparam logic [11:0] OFS_STATE_REQUEST = 12'h0120;
    localparam logic [11:0] OFS_STATE_REPORT  = 12'h0130;
    localparam logic [11:0] OFS_ERROR_CODE    = 12'h0134;
    localparam logic [11:0] OFS_LOCAL_CONFIG  = 12'h0140;
    localparam logic [11:0] OFS_FAULT_CAUSE   = 12'h0150;
    localparam logic [11:0] OFS_IRQ_STATUS    = 12'h0160;
    localparam logic [11:0] OFS_IRQ_CLEAR     = 12'h0164;
    localparam logic [11:0] OFS_IRQ_ENABLE    = 12'h0168;

    // Field positions.
    localparam int ERR_FLAG_BIT   = 4;
    localparam int ERR_ACK_BIT    = 4;
    localparam int EMU_ENABLE_BIT = 8;

    // Reset values.
    localparam logic [15:0] RST_ERROR_CODE   = 16'h0000;
    localparam logic        RST_EMU_ENABLE   = 1'b0;
    localparam logic [2:0]  RST_IRQ_ENABLE   = 3'h0;

    // State encodings shared by request and report.
    localparam logic [3:0] ST_INIT   = 4'h1;
    localparam logic [3:0] ST_PREOP  = 4'h2;
    localparam logic [3:0] ST_BOOT   = 4'h3;
    localparam logic [3:0] ST_SAFEOP = 4'h4;
    localparam logic [3:0] ST_OP     = 4'h8;

    // Error codes.
    localparam logic [15:0] EC_NONE       = 16'h0000;
    localparam logic [15:0] EC_BAD_CHANGE = 16'h0011;
    localparam logic [15:0] EC_UNKNOWN    = 16'h0012;
    localparam logic [15:0] EC_BUF_CFG    = 16'h0017;
    localparam logic [15:0] EC_NO_INPUTS  = 16'h0018;
    localparam logic [15:0] EC_BUF_TYPES  = 16'h001C;
    localparam logic [15:0] EC_COLD_START = 16'h0020;
    localparam logic [15:0] EC_SYNC_OUT   = 16'h0030;
    localparam logic [15:0] EC_TS_LATCH   = 16'h0031;
    localparam logic [15:0] EC_DT_TIMEOUT = 16'h0034;

    // Fault cause bits in the fault cause register.
    localparam int FC_BUF_CFG    = 0;
    localparam int FC_NO_INPUTS  = 1;
    localparam int FC_BUF_TYPES  = 2;
    localparam int FC_SYNC_OUT   = 3;
    localparam int FC_TS_LATCH   = 4;
    localparam int FC_DT_TIMEOUT = 5;
    localparam int FC_COLD_START = 6;
    localparam int FC_WIDTH      = 7;

    // Interrupt status bits.
    localparam int IRQ_ERROR   = 0;
    localparam int IRQ_CHANGE  = 1;
    localparam int IRQ_REQUEST = 2;
    localparam int IRQ_WIDTH   = 3;
endpackage

// ===== inc/ster_reg_if.sv
/*
 * Interface carrying register accesses from the bus slave to the state core.
 * Assumes one clock; strobes are single-cycle pulses.
 */
`timescale 1ns/100ps
interface ster_reg_if;
    logic        req_wr;
    logic [3:0]  req_state;
    logic        req_ack;
    logic        emu_en;
    logic [ster_pkg::FC_WIDTH-1:0] fault;
    logic [3:0]  cur_state;
    logic        err_flag;
    logic [15:0] err_code;
    logic        err_set;
    logic        state_chg;

    modport ctl  (output req_wr, req_state, req_ack, emu_en, fault,
                  input  cur_state, err_flag, err_code, err_set, state_chg);
    modport core (input  req_wr, req_state, req_ack, emu_en, fault,
                  output cur_state, err_flag, err_code, err_set, state_chg);
endinterface

// ===== rtl/ster_core.sv
/*
 * State core: decides resulting state, error flag and error code.
 * Assumes requests and fault causes are synchronous one-cycle inputs.
 */
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
module ster_core (
    // Clock and reset.
    input  wire logic i_core_clk,
    input  wire logic i_rst_b,
    // Register side.
    ster_reg_if.core  bus
);
    typedef struct packed {
        logic [3:0]  state;
        logic        flag;
        logic [15:0] code;
        logic        set;
        logic        chg;
    } ster_core_t;

    ster_core_t st_ff;
    ster_core_t nxt_st;

    function automatic logic is_known(input logic [3:0] s);
        return s == ster_pkg::ST_INIT || s == ster_pkg::ST_PREOP || s == ster_pkg::ST_BOOT
            || s == ster_pkg::ST_SAFEOP || s == ster_pkg::ST_OP;
    endfunction

    function automatic logic is_run(input logic [3:0] s);
        return s == ster_pkg::ST_OP || s == ster_pkg::ST_SAFEOP;
    endfunction

    always_comb begin
        logic        fail;
        logic [3:0]  cur;
        logic [3:0]  req;
        logic [3:0]  dst;
        logic [15:0] ec;
        logic        bad;
        logic        ps;
        logic        so;
        fail = 1'b0;
        cur  = st_ff.state;
        req  = bus.req_state;
        dst  = cur;
        ec   = ster_pkg::EC_NONE;
        bad  = 1'b0;
        ps   = 1'b0;
        so   = 1'b0;
        nxt_st = st_ff;
        nxt_st.set = 1'b0;
        nxt_st.chg = 1'b0;
        if (bus.req_ack) begin
            nxt_st.flag = 1'b0;
        end
        if (bus.req_wr && bus.emu_en) begin
            dst         = req;
            nxt_st.flag = bus.req_ack;
        end else if (bus.req_wr && req != cur) begin
            ps  = cur == ster_pkg::ST_PREOP && req == ster_pkg::ST_SAFEOP;
            so  = cur == ster_pkg::ST_SAFEOP && req == ster_pkg::ST_OP;
            bad = (cur == ster_pkg::ST_INIT && (req == ster_pkg::ST_SAFEOP || req == ster_pkg::ST_OP))
               || (cur == ster_pkg::ST_PREOP && (req == ster_pkg::ST_OP || req == ster_pkg::ST_BOOT))
               || ((cur == ster_pkg::ST_OP || cur == ster_pkg::ST_SAFEOP) && req == ster_pkg::ST_BOOT)
               || (cur == ster_pkg::ST_BOOT && req != ster_pkg::ST_INIT);
            if (!is_known(req)) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_UNKNOWN;
            end else if (bad) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_BAD_CHANGE;
            end else if ((ps || so) && bus.fault[ster_pkg::FC_BUF_CFG]) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_BUF_CFG;
            end else if (ps && bus.fault[ster_pkg::FC_NO_INPUTS]) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_NO_INPUTS;
                dst  = ster_pkg::ST_PREOP;
            end else if (ps && bus.fault[ster_pkg::FC_BUF_TYPES]) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_BUF_TYPES;
            end else begin
                dst = req;
            end
        end else if (bus.fault[ster_pkg::FC_COLD_START]) begin
            fail = 1'b1;
            ec   = ster_pkg::EC_COLD_START;
        end else if (is_run(cur)) begin
            if (bus.fault[ster_pkg::FC_NO_INPUTS]) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_NO_INPUTS;
                dst  = ster_pkg::ST_PREOP;
            end else if (bus.fault[ster_pkg::FC_BUF_TYPES]) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_BUF_TYPES;
                dst  = ster_pkg::ST_SAFEOP;
            end else if (bus.fault[ster_pkg::FC_SYNC_OUT]) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_SYNC_OUT;
                dst  = ster_pkg::ST_SAFEOP;
            end else if (bus.fault[ster_pkg::FC_TS_LATCH]) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_TS_LATCH;
                dst  = ster_pkg::ST_SAFEOP;
            end else if (bus.fault[ster_pkg::FC_DT_TIMEOUT]) begin
                fail = 1'b1;
                ec   = ster_pkg::EC_DT_TIMEOUT;
                dst  = ster_pkg::ST_SAFEOP;
            end
        end
        if (fail) begin
            nxt_st.flag = 1'b1;
            nxt_st.code = ec;
            nxt_st.set  = 1'b1;
        end else if (bus.req_wr && !bus.emu_en) begin
            nxt_st.code = ster_pkg::EC_NONE;
        end
        nxt_st.chg   = dst != cur;
        nxt_st.state = dst;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_ff <= '{state: ster_pkg::ST_INIT, flag: 1'b0, code: ster_pkg::RST_ERROR_CODE,
                       set: 1'b0, chg: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign bus.cur_state = st_ff.state;
    assign bus.err_flag  = st_ff.flag;
    assign bus.err_code  = st_ff.code;
    assign bus.err_set   = st_ff.set;
    assign bus.state_chg = st_ff.chg;
endmodule // ster_core

// ===== rtl/ster_top.sv
/*
 * Top of the state transition error reporting block: register port,
 * reset synchroniser, fault inputs, interrupt logic and the state core.
 * Assumes a single 250 MHz clock and synchronous fault inputs.
 */
`timescale 1ns/100ps

module ster_top (
    // Clock and reset.
    input  wire logic        i_core_clk,
    input  wire logic        i_rst_b,
    // Register port.
    input  wire logic [11:0] i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // Fault causes from the local application.
    input  wire logic [ster_pkg::FC_WIDTH-1:0] i_fault,
    // Interrupt.
    output logic             o_irq
);
    typedef struct packed {
        logic [15:0]                    rdata;
        logic                           emu_en;
        logic [ster_pkg::IRQ_WIDTH-1:0] irq_stat;
        logic [ster_pkg::IRQ_WIDTH-1:0] irq_en;
    } ster_top_t;

    ster_top_t   st_ff;
    ster_top_t   nxt_st;
    logic [1:0]  rst_sync_ff;
    logic        rst_b;
    ster_reg_if  rif ();

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_b = rst_sync_ff[1];

    always_comb begin
        logic [ster_pkg::IRQ_WIDTH-1:0] ev;
        ev = '0;
        nxt_st = st_ff;
        nxt_st.rdata = 16'h0000;
        ev[ster_pkg::IRQ_ERROR]   = rif.err_set;
        ev[ster_pkg::IRQ_CHANGE]  = rif.state_chg;
        ev[ster_pkg::IRQ_REQUEST] = rif.req_wr;
        if (i_wr && i_addr == ster_pkg::OFS_LOCAL_CONFIG) begin
            nxt_st.emu_en = i_wdata[ster_pkg::EMU_ENABLE_BIT];
        end
        if (i_wr && i_addr == ster_pkg::OFS_IRQ_ENABLE) begin
            nxt_st.irq_en = i_wdata[ster_pkg::IRQ_WIDTH-1:0];
        end
        if (i_wr && i_addr == ster_pkg::OFS_IRQ_CLEAR) begin
            nxt_st.irq_stat = st_ff.irq_stat & ~i_wdata[ster_pkg::IRQ_WIDTH-1:0];
        end
        nxt_st.irq_stat = nxt_st.irq_stat | ev;
        if (i_rd) begin
            case (i_addr)
                ster_pkg::OFS_STATE_REPORT: begin
                    nxt_st.rdata = {11'h000, rif.err_flag, rif.cur_state};
                end
                ster_pkg::OFS_ERROR_CODE: begin
                    nxt_st.rdata = rif.err_code;
                end
                ster_pkg::OFS_LOCAL_CONFIG: begin
                    nxt_st.rdata = {7'h00, st_ff.emu_en, 8'h00};
                end
                ster_pkg::OFS_FAULT_CAUSE: begin
                    nxt_st.rdata = {9'h000, i_fault};
                end
                ster_pkg::OFS_IRQ_STATUS: begin
                    nxt_st.rdata = {13'h0000, st_ff.irq_stat};
                end
                ster_pkg::OFS_IRQ_ENABLE: begin
                    nxt_st.rdata = {13'h0000, st_ff.irq_en};
                end
                default: begin
                    nxt_st.rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff.rdata    <= 16'h0000;
            st_ff.emu_en   <= ster_pkg::RST_EMU_ENABLE;
            st_ff.irq_stat <= '0;
            st_ff.irq_en   <= ster_pkg::RST_IRQ_ENABLE;
        end else begin
            st_ff.rdata    <= nxt_st.rdata;
            st_ff.emu_en   <= nxt_st.emu_en;
            st_ff.irq_stat <= nxt_st.irq_stat;
            st_ff.irq_en   <= nxt_st.irq_en;
        end
    end

    assign rif.req_wr    = i_wr && i_addr == ster_pkg::OFS_STATE_REQUEST;
    assign rif.req_state = i_wdata[3:0];
    assign rif.req_ack   = rif.req_wr && i_wdata[ster_pkg::ERR_ACK_BIT];
    assign rif.emu_en    = st_ff.emu_en;
    assign rif.fault     = i_fault;

    ster_core u_core (
        .i_core_clk (i_core_clk),
        .i_rst_b    (rst_b),
        .bus        (rif.core)
    );

    assign o_rdata = st_ff.rdata;
    assign o_irq   = |(st_ff.irq_stat & st_ff.irq_en);
endmodule // ster_top
